// File: src/rftx_pkg.sv
// rftx_pkg: register map, field layout, reset values and codes of the rf transmitter drive block
// assumes: apb slave with 32-bit data, registers one aligned word each, byte address = 4 * index
package rftx_pkg;

    // register indices as printed, byte address is four times the index
    localparam logic [7:0]  DRV_IDX       = 8'h28;
    localparam logic [7:0]  AMP_IDX       = 8'h29;
    localparam logic [7:0]  MOD_IDX       = 8'h2A;
    localparam logic [7:0]  OVS_IDX       = 8'h2B;
    localparam logic [11:0] DRV_ADDR      = {2'h0, DRV_IDX, 2'h0};
    localparam logic [11:0] AMP_ADDR      = {2'h0, AMP_IDX, 2'h0};
    localparam logic [11:0] MOD_ADDR      = {2'h0, MOD_IDX, 2'h0};
    localparam logic [11:0] OVS_ADDR      = {2'h0, OVS_IDX, 2'h0};

    // driver output control fields
    localparam int          DRV_OUT2_INV  = 7;
    localparam int          DRV_OUT1_INV  = 6;
    localparam int          DRV_ON        = 3;
    localparam int          DRV_SEL_LSB   = 0;
    localparam logic [7:0]  DRV_WMASK     = 8'hCF;
    // amplitude fields
    localparam int          AMP_RED_LSB   = 6;
    localparam int          AMP_RES_LSB   = 0;
    localparam logic [7:0]  AMP_WMASK     = 8'hDF;
    // modulation control fields
    localparam int          MOD_OVS_LSB   = 4;
    localparam int          MOD_MAX       = 3;
    localparam int          MOD_INV       = 2;
    localparam int          MOD_SRC_LSB   = 0;
    // overshoot and load fields
    localparam int          OVS_FIRST_LSB = 4;
    localparam int          OVS_TRIM_LSB  = 0;

    // reset values
    localparam logic [7:0]  DRV_RST       = 8'h00;
    localparam logic [7:0]  AMP_RST       = 8'h00;
    localparam logic [7:0]  MOD_RST       = 8'h00;
    localparam logic [7:0]  OVS_RST       = 8'h00;

    // output drive select codes
    localparam logic [2:0]  DRIVE_OPEN_DRAIN = 3'h0;
    localparam logic [2:0]  DRIVE_PUSH_PULL  = 3'h1;
    localparam logic [2:0]  DRIVE_HIGH_Z     = 3'h2;
    localparam logic [2:0]  DRIVE_FIX_LOW    = 3'h4;
    localparam logic [2:0]  DRIVE_FIX_HIGH   = 3'h5;

    // modulation source codes
    localparam logic [1:0]  SRC_NONE      = 2'h0;
    localparam logic [1:0]  SRC_ENVELOPE  = 2'h1;
    localparam logic [1:0]  SRC_SERIAL    = 2'h2;

    // carrier level reduction in mV, per code
    localparam int          RED_MV_0      = 100;
    localparam int          RED_MV_1      = 250;
    localparam int          RED_MV_2      = 500;
    localparam int          RED_MV_3      = 1000;

endpackage : rftx_pkg

// File: src/rftx_pin_drive.sv
// rftx_pin_drive: one antenna driver pin, polarity, enable and drive style
// assumes: carrier and modulation are synchronous to core_clk_i
`timescale 1ns/1ps
module rftx_pin_drive (
    // clock and reset
    input  wire logic       core_clk_i,
    input  wire logic       rst_n_i,
    // control
    input  wire logic       invert_i,
    input  wire logic       outputs_on_i,
    input  wire logic [2:0] drive_select_i,
    input  wire logic       level_i,
    // pin
    output logic            pin_o,
    output logic            pin_oe_o
);

    logic lvl;
    logic pin_nxt;
    logic oe_nxt;

    assign lvl = level_i ^ invert_i;

    always_comb begin
        pin_nxt = 1'b0;
        oe_nxt  = 1'b0;
        if (outputs_on_i) begin
            unique case (drive_select_i)
                rftx_pkg::DRIVE_OPEN_DRAIN: begin
                    pin_nxt = 1'b0;
                    oe_nxt  = ~lvl;
                end
                rftx_pkg::DRIVE_PUSH_PULL: begin
                    pin_nxt = lvl;
                    oe_nxt  = 1'b1;
                end
                rftx_pkg::DRIVE_FIX_LOW: begin
                    pin_nxt = invert_i;
                    oe_nxt  = 1'b1;
                end
                rftx_pkg::DRIVE_FIX_HIGH: begin
                    pin_nxt = ~invert_i;
                    oe_nxt  = 1'b1;
                end
                // high impedance and the unsupported codes leave the pin floating
                default: begin
                    pin_nxt = 1'b0;
                    oe_nxt  = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pin_o    <= 1'b0;
            pin_oe_o <= 1'b0;
        end else begin
            pin_o    <= pin_nxt;
            pin_oe_o <= oe_nxt;
        end
    end

endmodule : rftx_pin_drive

// File: src/rftx_drive_config.sv
// rftx_drive_config: apb register bank and modulation path for the two antenna drivers
// assumes: carrier_i and internal_envelope_i are on core_clk_i, external_serial_input_i is a pin
`timescale 1ns/1ps
module rftx_drive_config (
    // clock and reset
    input  wire logic        core_clk_i,
    input  wire logic        rst_n_i,
    // apb slave
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [11:0] paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    // modulation sources and carrier
    input  wire logic        carrier_i,
    input  wire logic        internal_envelope_i,
    input  wire logic        external_serial_input_i,
    // analog settings
    output logic      [1:0]  carrier_level_reduce_o,
    output logic             carrier_max_o,
    output logic      [4:0]  residual_carrier_o,
    output logic      [3:0]  overshoot_length_o,
    output logic      [3:0]  overshoot_first_value_o,
    output logic      [3:0]  load_current_trim_o,
    output logic             modulation_o,
    // driver pins
    output logic             driver_pin_one_o,
    output logic             driver_pin_one_oe_o,
    output logic             driver_pin_two_o,
    output logic             driver_pin_two_oe_o
);

    ////////////////////////////////////////////////////////////////////////////////
    // registers

    logic [7:0] drv_r;
    logic [7:0] amp_r;
    logic [7:0] mod_r;
    logic [7:0] ovs_r;
    logic       wr_en;
    logic       hit;
    logic [7:0] rd_nxt;
    logic       sel_drv;
    logic       sel_amp;
    logic       sel_mod;
    logic       sel_ovs;
    logic       wr_drv;
    logic       wr_amp;
    logic       wr_mod;
    logic       wr_ovs;

    // zero wait states: every access completes in its first access cycle
    assign pready_o = 1'b1;
    assign wr_en    = psel_i & penable_i & pwrite_i;

    // one address decoder feeds all four write strobes
    assign sel_drv  = (paddr_i == rftx_pkg::DRV_ADDR);
    assign sel_amp  = (paddr_i == rftx_pkg::AMP_ADDR);
    assign sel_mod  = (paddr_i == rftx_pkg::MOD_ADDR);
    assign sel_ovs  = (paddr_i == rftx_pkg::OVS_ADDR);
    assign wr_drv   = wr_en & sel_drv;
    assign wr_amp   = wr_en & sel_amp;
    assign wr_mod   = wr_en & sel_mod;
    assign wr_ovs   = wr_en & sel_ovs;

    always_comb begin
        hit    = 1'b1;
        rd_nxt = 8'h00;
        unique case (paddr_i)
            rftx_pkg::DRV_ADDR: rd_nxt = drv_r;
            rftx_pkg::AMP_ADDR: rd_nxt = amp_r;
            rftx_pkg::MOD_ADDR: rd_nxt = mod_r;
            rftx_pkg::OVS_ADDR: rd_nxt = ovs_r;
            default:            hit    = 1'b0;
        endcase
    end

    // unmapped addresses answer with an error and zero data
    assign pslverr_o = psel_i & penable_i & ~hit;
    assign prdata_o  = {24'h000000, rd_nxt};

    // reserved bits are masked on the way in, so the read mux needs no mask
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            drv_r <= rftx_pkg::DRV_RST;
        end else if (wr_drv) begin
            drv_r <= pwdata_i[7:0] & rftx_pkg::DRV_WMASK;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            amp_r <= rftx_pkg::AMP_RST;
        end else if (wr_amp) begin
            amp_r <= pwdata_i[7:0] & rftx_pkg::AMP_WMASK;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mod_r <= rftx_pkg::MOD_RST;
        end else if (wr_mod) begin
            mod_r <= pwdata_i[7:0];
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ovs_r <= rftx_pkg::OVS_RST;
        end else if (wr_ovs) begin
            ovs_r <= pwdata_i[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // analog settings

    // settings are registered so the analog stage never sees a decode glitch
    logic carrier_max;
    assign carrier_max = mod_r[rftx_pkg::MOD_MAX];

    // with max carrier set the reduction is forced to zero so it has no effect
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            carrier_level_reduce_o <= 2'h0;
        end else begin
            carrier_level_reduce_o <= carrier_max ? 2'h0 : amp_r[rftx_pkg::AMP_RED_LSB +: 2];
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            carrier_max_o <= 1'b0;
        end else begin
            carrier_max_o <= carrier_max;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            residual_carrier_o <= 5'h00;
        end else begin
            residual_carrier_o <= amp_r[rftx_pkg::AMP_RES_LSB +: 5];
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            overshoot_length_o <= 4'h0;
        end else begin
            overshoot_length_o <= mod_r[rftx_pkg::MOD_OVS_LSB +: 4];
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            overshoot_first_value_o <= 4'h0;
        end else begin
            overshoot_first_value_o <= ovs_r[rftx_pkg::OVS_FIRST_LSB +: 4];
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            load_current_trim_o <= 4'h0;
        end else begin
            load_current_trim_o <= ovs_r[rftx_pkg::OVS_TRIM_LSB +: 4];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // modulation path

    logic serial_meta_r;
    logic serial_sync_r;
    logic mod_sel;
    logic carrier_prev_r;
    logic mod_prev_r;
    logic [3:0] ext_cnt_r;
    logic mod_eff;

    logic [3:0] ovs_len;
    logic       mod_fall;
    logic       ext_act;

    // the serial input is a pin, so it is resynchronised first
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            serial_meta_r <= 1'b0;
            serial_sync_r <= 1'b0;
        end else begin
            serial_meta_r <= external_serial_input_i;
            serial_sync_r <= serial_meta_r;
        end
    end

    always_comb begin
        mod_sel = 1'b0;
        unique case (mod_r[rftx_pkg::MOD_SRC_LSB +: 2])
            rftx_pkg::SRC_NONE:     mod_sel = 1'b0;
            rftx_pkg::SRC_ENVELOPE: mod_sel = internal_envelope_i;
            rftx_pkg::SRC_SERIAL:   mod_sel = serial_sync_r;
            default:                mod_sel = 1'b0;
        endcase
    end

    // carrier and source history for the edge and fall detectors
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            carrier_prev_r <= 1'b0;
        end else begin
            carrier_prev_r <= carrier_i;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mod_prev_r <= 1'b0;
        end else begin
            mod_prev_r <= mod_sel;
        end
    end

    assign ovs_len  = mod_r[rftx_pkg::MOD_OVS_LSB +: 4];
    assign mod_fall = mod_prev_r & ~mod_sel;

    // modulation is extended by overshoot_length carrier cycles after it ends
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ext_cnt_r <= 4'h0;
        end else if (mod_fall) begin
            ext_cnt_r <= ovs_len;
        end else if (ext_cnt_r != 4'h0 && carrier_i && !carrier_prev_r) begin
            ext_cnt_r <= ext_cnt_r - 4'h1;
        end
    end

    // the fall cycle already counts as extension, so no gap opens before the counter loads
    assign ext_act = (ext_cnt_r != 4'h0) | (mod_fall & (ovs_len != 4'h0));

    // inversion is applied after the source choice, as one stage
    assign mod_eff = (mod_sel | ext_act) ^ mod_r[rftx_pkg::MOD_INV];

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            modulation_o <= 1'b0;
        end else begin
            modulation_o <= mod_eff;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // driver pins

    logic [1:0] pin_inv;
    logic [1:0] pin_val;
    logic [1:0] pin_oe;

    // index 0 is driver pin one, index 1 driver pin two
    assign pin_inv = {drv_r[rftx_pkg::DRV_OUT2_INV], drv_r[rftx_pkg::DRV_OUT1_INV]};

    // both pins share enable and drive style; only their inversion differs
    // unsupported drive codes (software must avoid) fall to high impedance
    for (genvar g = 0; g < 2; g++) begin : g_pin
        rftx_pin_drive u_pin (
            .core_clk_i     (core_clk_i),
            .rst_n_i        (rst_n_i),
            .invert_i       (pin_inv[g]),
            .outputs_on_i   (drv_r[rftx_pkg::DRV_ON]),
            .drive_select_i (drv_r[rftx_pkg::DRV_SEL_LSB +: 3]),
            .level_i        (carrier_i),
            .pin_o          (pin_val[g]),
            .pin_oe_o       (pin_oe[g])
        );
    end

    assign driver_pin_one_o    = pin_val[0];
    assign driver_pin_one_oe_o = pin_oe[0];
    assign driver_pin_two_o    = pin_val[1];
    assign driver_pin_two_oe_o = pin_oe[1];

endmodule : rftx_drive_config

// File: verif/rftx_antenna_model.sv
// rftx_antenna_model: antenna network seen at the two driver pins
// assumes: each pin has a pull-up, as open-drain drive needs
`timescale 1ns/1ps
module rftx_antenna_model (
    // driver side
    input  wire logic pin_one_i,
    input  wire logic pin_one_oe_i,
    input  wire logic pin_two_i,
    input  wire logic pin_two_oe_i,
    // resolved line levels
    output logic      line_one_o,
    output logic      line_two_o
);
    // a released pin goes to the pull-up, never holds its last level
    assign line_one_o = pin_one_oe_i ? pin_one_i : 1'b1;
    assign line_two_o = pin_two_oe_i ? pin_two_i : 1'b1;
endmodule : rftx_antenna_model

// File: verif/rftx_drive_config_sva.sv
// rftx_drive_config_sva: port assertions of the drive config block
// assumes: zero-wait apb, settings show two edges after the write edge
`timescale 1ns/1ps
module rftx_drive_config_sva (
    input wire logic        core_clk_i,
    input wire logic        rst_n_i,
    input wire logic        psel_i,
    input wire logic        penable_i,
    input wire logic        pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [31:0] prdata_o,
    input wire logic        pslverr_o,
    input wire logic [1:0]  carrier_level_reduce_o,
    input wire logic        carrier_max_o,
    input wire logic [4:0]  residual_carrier_o,
    input wire logic [3:0]  overshoot_length_o,
    input wire logic [3:0]  overshoot_first_value_o,
    input wire logic [3:0]  load_current_trim_o,
    input wire logic        driver_pin_one_oe_o,
    input wire logic        driver_pin_two_oe_o
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);
    logic       acc;
    logic       wr;
    logic [7:0] wd;
    assign acc = psel_i & penable_i;
    assign wr  = acc & pwrite_i;
    assign wd  = pwdata_i[7:0];
    ////////////////////////////////////////////////////////////////////////
    amp_res_a: assert property (wr && paddr_i == rftx_pkg::AMP_ADDR |-> ##2
        {3'h0, residual_carrier_o} == ($past(wd, 2) & 8'h1F)) else $error("residual setting wrong");
    amp_red_a: assert property (wr && paddr_i == rftx_pkg::AMP_ADDR |-> ##2 carrier_max_o ||
        {carrier_level_reduce_o, 6'h00} == ($past(wd, 2) & 8'hC0)) else $error("level reduce wrong");
    max_zero_a: assert property (carrier_max_o |-> carrier_level_reduce_o == 2'h0)
        else $error("reduce not ignored");
    mod_wr_a: assert property (wr && paddr_i == rftx_pkg::MOD_ADDR |-> ##2
        {overshoot_length_o, carrier_max_o, 3'h0} == ($past(wd, 2) & 8'hF8)) else $error("mod setting wrong");
    ovs_wr_a: assert property (wr && paddr_i == rftx_pkg::OVS_ADDR |-> ##2
        {overshoot_first_value_o, load_current_trim_o} == $past(wd, 2)) else $error("overshoot trim wrong");
    rsv_zero_a: assert property (acc && !pwrite_i && paddr_i == rftx_pkg::DRV_ADDR |->
        (prdata_o & 32'hFFFF_FF30) == 32'h0000_0000) else $error("reserved bits not zero");
    oe_off_a: assert property (wr && paddr_i == rftx_pkg::DRV_ADDR && !wd[3] |-> ##2
        !driver_pin_one_oe_o && !driver_pin_two_oe_o) else $error("pins on while disabled");
    pin_hiz_a: assert property (wr && paddr_i == rftx_pkg::DRV_ADDR && wd[2:0] == rftx_pkg::DRIVE_HIGH_Z |->
        ##2 !driver_pin_one_oe_o && !driver_pin_two_oe_o) else $error("high-z pins driven");
    drv_wr_c: cover property (wr && paddr_i == rftx_pkg::DRV_ADDR);
    bad_adr_c: cover property (acc && pslverr_o);
    max_on_c: cover property (carrier_max_o);
endmodule : rftx_drive_config_sva

bind rftx_drive_config rftx_drive_config_sva i_sva (.*);

// File: verif/tb_top.sv
// tb_top: register, pin and modulation tests of the drive config block
// assumes: zero-wait apb slave, pins settle within three edges of a write
`timescale 1ns/1ps
module tb_top;
    logic        core_clk_i = 0, rst_n_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0;
    logic [11:0] paddr_i = 12'h000;
    logic [31:0] pwdata_i = 32'h0000_0000, prdata_o, rd;
    logic        carrier_i = 0, internal_envelope_i = 1, external_serial_input_i = 0, car_run = 0;
    logic        pready_o, pslverr_o, carrier_max_o, modulation_o, se, line_one, line_two;
    logic [1:0]  carrier_level_reduce_o;
    logic [4:0]  residual_carrier_o;
    logic [3:0]  overshoot_length_o, overshoot_first_value_o, load_current_trim_o;
    logic        driver_pin_one_o, driver_pin_one_oe_o, driver_pin_two_o, driver_pin_two_oe_o;
    int          err_total = 0, samples_checked = 0, ext_hi = 0;
    localparam logic [11:0] AD [4] = '{rftx_pkg::DRV_ADDR, rftx_pkg::AMP_ADDR, rftx_pkg::MOD_ADDR,
                                       rftx_pkg::OVS_ADDR};
    localparam logic [7:0]  WM [4] = '{rftx_pkg::DRV_WMASK, rftx_pkg::AMP_WMASK, 8'hFF, 8'hFF};
    // codes 3, 6 and 7 are left out on purpose, software never sets them
    localparam logic [2:0]  CD [5] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5};
    // per code index: pins driven, and line level with the carrier held low
    localparam logic [4:0]  OE_EXP = 5'h1B;
    localparam logic [4:0]  LN_EXP = 5'h14;
    rftx_drive_config i_dut (.*);
    rftx_antenna_model i_ant (.pin_one_i(driver_pin_one_o), .pin_one_oe_i(driver_pin_one_oe_o),
        .pin_two_i(driver_pin_two_o), .pin_two_oe_i(driver_pin_two_oe_o),
        .line_one_o(line_one), .line_two_o(line_two));
    always #5 core_clk_i = ~core_clk_i;
    always @(posedge core_clk_i) if (car_run) carrier_i <= ~carrier_i;
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
        @(posedge core_clk_i);
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= {24'h000000, d};
        @(posedge core_clk_i);
        penable_i <= 1'b1;
        @(posedge core_clk_i);
        while (pready_o !== 1'b1) begin
            @(posedge core_clk_i);
        end
        rd = prdata_o;
        se = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask : apb
    task automatic settle(input int c);
        repeat (c) @(posedge core_clk_i);
        @(negedge core_clk_i);
    endtask : settle
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : give_verdict
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (10) @(posedge core_clk_i);
        rst_n_i <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            apb(1'b0, AD[i], 8'h00);
            chk("reset value", 32'h0000_0000, rd);
            apb(1'b1, AD[i], 8'hFF);
            apb(1'b0, AD[i], 8'h00);
            chk("readback", {24'h000000, WM[i]}, rd);
        end
        settle(3);
        chk("settings", 32'h0003_FFFF, {carrier_max_o, residual_carrier_o, overshoot_length_o,
            overshoot_first_value_o, load_current_trim_o});
        chk("max reduce", 32'h0000_0000, carrier_level_reduce_o);
        apb(1'b1, 12'h0B0, 8'hFF);
        chk("unmapped write error", 32'h0000_0001, se);
        apb(1'b0, 12'h0B0, 8'h00);
        chk("unmapped data", 32'h0000_0000, rd);
        chk("unmapped read error", 32'h0000_0001, se);
        $display("test registers done");
        apb(1'b1, rftx_pkg::MOD_ADDR, 8'h00);
        for (int k = 0; k < 4; k++) begin
            apb(1'b1, rftx_pkg::AMP_ADDR, {k[1:0], 6'h00});
            settle(3);
            chk("level reduce", k, carrier_level_reduce_o);
        end
        $display("test level done");
        for (int i = 0; i < 5; i++) begin
            apb(1'b1, rftx_pkg::DRV_ADDR, {5'h01, CD[i]});
            settle(3);
            chk("drive oe", {2{OE_EXP[i]}}, {driver_pin_two_oe_o, driver_pin_one_oe_o});
            chk("drive line", {2{LN_EXP[i]}}, {line_two, line_one});
        end
        for (int j = 0; j < 4; j++) begin
            apb(1'b1, rftx_pkg::DRV_ADDR, {j[1:0], 3'h1, rftx_pkg::DRIVE_PUSH_PULL});
            settle(3);
            chk("invert", j, {line_two, line_one});
        end
        apb(1'b1, rftx_pkg::DRV_ADDR, {5'h00, rftx_pkg::DRIVE_PUSH_PULL});
        settle(3);
        chk("outputs off", 32'h0000_0000, {driver_pin_two_oe_o, driver_pin_one_oe_o});
        $display("test pins done");
        car_run = 1'b1;
        // envelope and serial input take opposite levels so every source is told apart
        for (int m = 0; m < 16; m++) begin
            apb(1'b1, rftx_pkg::MOD_ADDR, {5'h00, m[2:0]});
            internal_envelope_i <= m[3];
            external_serial_input_i <= ~m[3];
            settle(8);
            chk("modulation", ((m[1:0] == 2'h1) & m[3] | (m[1:0] == 2'h2) & ~m[3]) ^ m[2], modulation_o);
        end
        apb(1'b1, rftx_pkg::MOD_ADDR, {4'h3, 2'h0, rftx_pkg::SRC_ENVELOPE});
        internal_envelope_i <= 1'b1;
        settle(4);
        // drop the envelope on an edge where the carrier falls, so it rises on the next one
        @(posedge core_clk_i);
        while (carrier_i !== 1'b1) begin
            @(posedge core_clk_i);
        end
        internal_envelope_i <= 1'b0;
        @(posedge core_clk_i);
        repeat (16) begin
            @(negedge core_clk_i);
            ext_hi += modulation_o;
        end
        // three carrier periods of two core cycles each
        chk("overshoot span", 32'h0000_0006, ext_hi);
        $display("test modulation done");
        give_verdict();
    end
    initial begin
        repeat (5000) @(posedge core_clk_i);
        err_total++;
        give_verdict();
    end
endmodule : tb_top
